// *** hdl/iav_pkg.sv ***
// Package for the interrupt autovector block: offsets, layouts, reset values, carriers
package iav_pkg;

    // Source counts per shared line
    localparam int USB_SRC_CNT  = 27;
    localparam int FIFO_SRC_CNT = 14;

    // Jump-table locations fetched by the core
    localparam logic [15:0] USB_JUMP_ADDR  = 16'h0043;
    localparam logic [15:0] USB_PAGE_ADDR  = 16'h0044;
    localparam logic [15:0] USB_VEC_ADDR   = 16'h0045;
    localparam logic [15:0] FIFO_JUMP_ADDR = 16'h0053;
    localparam logic [15:0] FIFO_PAGE_ADDR = 16'h0054;
    localparam logic [15:0] FIFO_VEC_ADDR  = 16'h0055;

    // Vector byte layout: base plus four bytes per source
    localparam logic [7:0] USB_VEC_BASE  = 8'h00;
    localparam logic [7:0] FIFO_VEC_BASE = 8'h80;
    localparam int         VEC_STEP_LSB  = 2;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_SETUP     = 8'h00;
    localparam logic [7:0] OFS_USB_EN    = 8'h04;
    localparam logic [7:0] OFS_FIFO_EN   = 8'h08;
    localparam logic [7:0] OFS_USB_PEND  = 8'h0c;
    localparam logic [7:0] OFS_FIFO_PEND = 8'h10;
    localparam logic [7:0] OFS_VECTORS   = 8'h14;

    // Field positions in the setup register
    localparam int SETUP_USB_AV_BIT  = 3;
    localparam int SETUP_FIFO_AV_BIT = 1;

    // Values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } iav_wb_req_t;

    // Code fetch from the core, with the byte read from code memory
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  memByte;
    } iav_fetch_t;

endpackage : iav_pkg

// *** hdl/iav_autovector.sv ***
// Second-level interrupt vectoring for the USB and FIFO shared lines
//
// Notes on behaviour
// - Merge 27 USB sources onto one line
// - USB interrupt jump sits at 0x0043
// - USB vector replaces byte at 0x0045 when enabled
// - Merge 14 FIFO sources, also autovectored
// - Programmable flags: priorities 1-4, vectors 80-8C
// - Empty flags: priorities 5-8, vectors 90-9C
// - Full flags: priorities 9-12, vectors A0-AC
// - Done is 13/B0; highest pending wins
// - FIFO interrupt jump sits at 0x0053
// - FIFO vector replaces byte at 0x0055 when enabled
// - Wait event is fourteenth, vector B4
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module iav_autovector
    import iav_pkg::*;
(
    // Clock, reset, freeze
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Wishbone slave
    input  wire iav_wb_req_t wbReq,
    output logic             wbAck,
    output logic [31:0]      wbDatOut,
    // Event pulses from the peripherals, same clock
    input  wire logic [USB_SRC_CNT-1:0]  usbEvent,
    input  wire logic [FIFO_SRC_CNT-1:0] fifoEvent,
    // Shared request lines to the core
    output logic             usbSharedIrq,
    output logic             fifoSharedIrq,
    // Code fetch path
    input  wire iav_fetch_t  fetchReq,
    output logic [7:0]       fetchByte,
    output logic             fetchByteValid
);

    // Index of lowest set bit; bit 0 is the highest priority
    // Scan runs downwards so the lowest set index is the one kept
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[4:0];
            end
        end
        return idx;
    endfunction : first_set

    // Vector byte for a source index: base plus four per step
    function automatic logic [7:0] vec_of(input logic [7:0] base, input logic [4:0] idx);
        return base + {1'b0, idx, 2'b00};
    endfunction : vec_of

    // Byte-lane selects expanded to a bit mask for merging write data
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // Registered state
    logic                    usbAv_q,    usbAv_d;     // USB autovector enable
    logic                    fifoAv_q,   fifoAv_d;    // FIFO autovector enable
    logic [USB_SRC_CNT-1:0]  usbEn_q,    usbEn_d;     // USB source enables
    logic [FIFO_SRC_CNT-1:0] fifoEn_q,   fifoEn_d;    // FIFO source enables
    logic [USB_SRC_CNT-1:0]  usbPend_q,  usbPend_d;   // USB sticky flags
    logic [FIFO_SRC_CNT-1:0] fifoPend_q, fifoPend_d;  // FIFO sticky flags
    logic [7:0]              usbVec_q,   usbVec_d;    // Current USB vector byte
    logic [7:0]              fifoVec_q,  fifoVec_d;   // Current FIFO vector byte
    logic                    usbIrq_q,   usbIrq_d;    // USB line
    logic                    fifoIrq_q,  fifoIrq_d;   // FIFO line
    logic                    ack_q,      ack_d;       // Bus acknowledge
    logic [31:0]             rdat_q,     rdat_d;      // Bus read data
    logic [7:0]              fbyte_q,    fbyte_d;     // Fetched byte to core
    logic                    fvalid_q,   fvalid_d;    // Fetched byte strobe

    // Bus decode helpers
    logic        access;     // New access this cycle
    logic        wrAccess;   // New write
    logic [31:0] wmask;      // Byte lanes as bits
    logic [31:0] setupWord;  // Setup register as read
    logic [31:0] usbEnNew;   // Merged enable write
    logic [31:0] fifoEnNew;  // Merged enable write
    logic [31:0] usbClr;     // Write-one-to-clear mask
    logic [31:0] fifoClr;    // Write-one-to-clear mask
    logic [31:0] usbLive;    // Pending and enabled, padded
    logic [31:0] fifoLive;   // Pending and enabled, padded

    // Next-state logic for registers, flags, vectors and fetch
    always_comb begin
        // Hold by default
        usbAv_d    = usbAv_q;
        fifoAv_d   = fifoAv_q;
        usbEn_d    = usbEn_q;
        fifoEn_d   = fifoEn_q;
        rdat_d     = rdat_q;
        // ce low freezes ack too, so a master keeps ce high through a cycle
        // One access per ack; ack drops the cycle after it rose
        access     = wbReq.cyc & wbReq.stb & ~ack_q;
        wrAccess   = access & wbReq.we;
        ack_d      = access;
        wmask      = lane_mask(wbReq.sel);
        setupWord  = RST_WORD;
        setupWord[SETUP_USB_AV_BIT]  = usbAv_q;
        setupWord[SETUP_FIFO_AV_BIT] = fifoAv_q;
        usbEnNew   = ({5'h00, usbEn_q} & ~wmask) | (wbReq.dat & wmask);
        fifoEnNew  = ({18'h00000, fifoEn_q} & ~wmask) | (wbReq.dat & wmask);
        usbClr     = RST_WORD;
        fifoClr    = RST_WORD;

        // Register writes; unmapped offsets are acked and ignored
        if (wrAccess) begin
            case (wbReq.adr)
                OFS_SETUP: begin
                    if (wbReq.sel[0]) begin
                        usbAv_d  = wbReq.dat[SETUP_USB_AV_BIT];
                        fifoAv_d = wbReq.dat[SETUP_FIFO_AV_BIT];
                    end
                end
                OFS_USB_EN:    usbEn_d  = usbEnNew[USB_SRC_CNT-1:0];
                OFS_FIFO_EN:   fifoEn_d = fifoEnNew[FIFO_SRC_CNT-1:0];
                OFS_USB_PEND:  usbClr   = wbReq.dat & wmask;
                OFS_FIFO_PEND: fifoClr  = wbReq.dat & wmask;
                default:       ;  // Read-only or unmapped
            endcase
        end

        // Register reads; unmapped reads return zero
        if (access && !wbReq.we) begin
            case (wbReq.adr)
                OFS_SETUP:     rdat_d = setupWord;
                OFS_USB_EN:    rdat_d = {5'h00, usbEn_q};
                OFS_FIFO_EN:   rdat_d = {18'h00000, fifoEn_q};
                OFS_USB_PEND:  rdat_d = {5'h00, usbPend_q};
                OFS_FIFO_PEND: rdat_d = {18'h00000, fifoPend_q};
                OFS_VECTORS:   rdat_d = {16'h0000, fifoVec_q, usbVec_q};
                default:       rdat_d = RST_WORD;
            endcase
        end

        // Sticky flags: a new event beats a clear in the same cycle
        // Only a software write or reset clears a flag; an event held high keeps setting it
        usbPend_d  = (usbPend_q & ~usbClr[USB_SRC_CNT-1:0]) | usbEvent;
        fifoPend_d = (fifoPend_q & ~fifoClr[FIFO_SRC_CNT-1:0]) | fifoEvent;

        // Only enabled pending sources drive a line
        usbLive  = {5'h00, usbPend_d & usbEn_d};
        fifoLive = {18'h00000, fifoPend_d & fifoEn_d};
        usbIrq_d  = |usbLive;
        fifoIrq_d = |fifoLive;

        // Lowest index is highest priority; vectors step by four
        // Vectors follow the next flag state so they agree with the line
        usbVec_d  = vec_of(USB_VEC_BASE, first_set(usbLive));
        // Index 0-3 flags, 4-7 empty, 8-11 full, 12 done, 13 wait
        fifoVec_d = vec_of(FIFO_VEC_BASE, first_set(fifoLive));

        // Fetch path: pass memory byte unless a vector slot is enabled
        // Jump opcode and page byte always come from code memory, so
        // software must preload the page; only the low byte is replaced
        fvalid_d = fetchReq.valid;
        fbyte_d  = fetchReq.memByte;
        if (fetchReq.valid) begin
            if (usbAv_q && fetchReq.addr == USB_VEC_ADDR) begin
                fbyte_d = usbVec_q;
            end else if (fifoAv_q && fetchReq.addr == FIFO_VEC_ADDR) begin
                fbyte_d = fifoVec_q;
            end
        end
    end

    // State registers; ce low freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usbAv_q    <= 1'b0;
            fifoAv_q   <= 1'b0;
            usbEn_q    <= '0;
            fifoEn_q   <= '0;
            usbPend_q  <= '0;
            fifoPend_q <= '0;
            usbVec_q   <= USB_VEC_BASE;
            fifoVec_q  <= FIFO_VEC_BASE;
            usbIrq_q   <= 1'b0;
            fifoIrq_q  <= 1'b0;
            ack_q      <= 1'b0;
            rdat_q     <= RST_WORD;
            fbyte_q    <= RST_BYTE;
            fvalid_q   <= 1'b0;
        end else if (ce) begin
            usbAv_q    <= usbAv_d;
            fifoAv_q   <= fifoAv_d;
            usbEn_q    <= usbEn_d;
            fifoEn_q   <= fifoEn_d;
            usbPend_q  <= usbPend_d;
            fifoPend_q <= fifoPend_d;
            usbVec_q   <= usbVec_d;
            fifoVec_q  <= fifoVec_d;
            usbIrq_q   <= usbIrq_d;
            fifoIrq_q  <= fifoIrq_d;
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
            fbyte_q    <= fbyte_d;
            fvalid_q   <= fvalid_d;
        end
    end

    // Outputs straight from flops
    assign wbAck          = ack_q;
    assign wbDatOut       = rdat_q;
    assign usbSharedIrq   = usbIrq_q;
    assign fifoSharedIrq  = fifoIrq_q;
    assign fetchByte      = fbyte_q;
    assign fetchByteValid = fvalid_q;

endmodule : iav_autovector

`default_nettype wire

// *** dv/iav_sva.sv ***
// Port assertions for the interrupt autovector block
`timescale 1ns/1ps
`default_nettype none
module iav_sva
    import iav_pkg::*;
(
    // Clock, reset and freeze
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    ce,
    // Bus
    input wire iav_wb_req_t             wbReq,
    input wire logic                    wbAck,
    input wire logic [31:0]             wbDatOut,
    // Events and lines
    input wire logic [USB_SRC_CNT-1:0]  usbEvent,
    input wire logic [FIFO_SRC_CNT-1:0] fifoEvent,
    input wire logic                    usbSharedIrq,
    input wire logic                    fifoSharedIrq,
    // Fetch path
    input wire iav_fetch_t              fetchReq,
    input wire logic [7:0]              fetchByte,
    input wire logic                    fetchByteValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A fetch taken at the USB or the FIFO vector slot
    wire logic usbV = ce && fetchReq.valid && fetchReq.addr == USB_VEC_ADDR;
    wire logic fifoV = ce && fetchReq.valid && fetchReq.addr == FIFO_VEC_ADDR;
    a_ack_next_cycle: assert property (ce && wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
        else $error("bus ack missing");
    a_fetch_answer: assert property (ce && fetchReq.valid |=> fetchByteValid)
        else $error("fetch not answered");
    a_fetch_passes_through: assert property (ce && fetchReq.valid && !usbV && !fifoV |=>
        fetchByte == $past(fetchReq.memByte)) else $error("fetched byte altered");
    a_usb_vector_form: assert property (usbV |=> fetchByte == $past(fetchReq.memByte)
        || (fetchByte[1:0] == 2'b00 && fetchByte <= 8'h68)) else $error("bad usb vector");
    a_fifo_vector_form: assert property (fifoV |=> fetchByte == $past(fetchReq.memByte)
        || (fetchByte[1:0] == 2'b00 && fetchByte inside {[8'h80:8'hb4]})) else $error("bad fifo vector");
    a_usb_line_cause: assert property ($rose(usbSharedIrq) |-> $past(|usbEvent) || wbAck)
        else $error("usb line rose without cause");
    a_fifo_line_cause: assert property ($rose(fifoSharedIrq) |-> $past(|fifoEvent) || wbAck)
        else $error("fifo line rose without cause");
    a_fifo_line_holds: assert property ($fell(fifoSharedIrq) |-> wbAck)
        else $error("fifo line dropped without write");
    a_usb_line_holds: assert property ($fell(usbSharedIrq) |-> wbAck)
        else $error("usb line dropped without write");
    c_fifo_vector: cover property (fifoV && fifoSharedIrq);
    c_usb_rise: cover property ($rose(usbSharedIrq));
    c_read: cover property (wbAck && !wbReq.we);
endmodule : iav_sva
`default_nettype wire

// *** dv/iav_core_model.sv ***
// Core model fetching the jump, page and vector bytes of one line
`timescale 1ns/1ps
`default_nettype none
module iav_core_model
    import iav_pkg::*;
(
    // Clock and command
    input wire logic clk,
    input wire logic go,
    input wire logic isFifo,
    // Fetch toward the block
    output iav_fetch_t fetchReq
);
    logic [1:0]  left_q = 2'd0;   // Fetches still to come
    logic        act_q = 1'b0;    // Fetch cycle live
    logic [15:0] addr_q = 16'h0;  // Fetch address
    logic [7:0]  idle_q = 8'h00;  // Churns so a stale byte never passes
    // Three back-to-back fetches per command
    always @(posedge clk) begin
        act_q <= go || left_q != 2'd0;
        idle_q <= ~idle_q;
        if (go) begin
            left_q <= 2'd2;
            addr_q <= isFifo ? FIFO_JUMP_ADDR : USB_JUMP_ADDR;
        end else if (left_q != 2'd0) begin
            left_q <= left_q - 2'd1;
            addr_q <= addr_q + 16'd1;
        end
    end
    // Code memory; page byte preloaded by software
    assign fetchReq = '{act_q, addr_q, act_q ? addr_q[7:0] ^ 8'ha5 : idle_q};
endmodule : iav_core_model
`default_nettype wire

// *** dv/test_interrupt_autovector.sv ***
// Self-checking bench for the interrupt autovector block
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_autovector import iav_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, go = 1'b0, isFifo = 1'b0;
    logic wbAck, usbSharedIrq, fifoSharedIrq, fetchByteValid;
    logic [USB_SRC_CNT-1:0] usbEvent = '0;
    logic [FIFO_SRC_CNT-1:0] fifoEvent = '0;
    logic [31:0] wbDatOut, expRd[$];
    logic [7:0] expB[$];
    logic [7:0] fetchByte;
    iav_wb_req_t wbReq = '0;
    iav_fetch_t fetchReq;
    int nErrors = 0, totalChecks = 0;
    integer seed = 32'h14aaca8d;
    iav_autovector DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
        .usbEvent(usbEvent), .fifoEvent(fifoEvent), .usbSharedIrq(usbSharedIrq), .fifoSharedIrq(fifoSharedIrq),
        .fetchReq(fetchReq), .fetchByte(fetchByte), .fetchByteValid(fetchByteValid));
    iav_core_model core (.clk(clk), .go(go), .isFifo(isFifo), .fetchReq(fetchReq));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Fetched bytes and line levels, zero-padded into the shared compare
    task automatic chkByte(input logic [7:0] exp, input logic [7:0] got);
        chk({24'h0, exp}, {24'h0, got});
    endtask : chkByte
    task automatic chkLine(input logic exp, input logic got);
        chk({31'h0, exp}, {31'h0, got});
    endtask : chkLine
    task automatic wrapUp();
        // A note never matched by a result counts as a mismatch
        if (expB.size() != 0 || expRd.size() != 0) begin
            nErrors++;
            $display("[ERR] %0t results never came", $time);
        end
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrapUp
    // One classic cycle; reads leave a note
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        if (!we) expRd.push_back(dat);
        @(posedge clk);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        t = 0;
        do begin @(posedge clk); t++; end while (wbAck !== 1'b1 && t < 20);
        if (t >= 20) begin nErrors++; wrapUp(); end
        wbReq <= '0;
    endtask : bus
    // Pulse source i plus random lower-priority ones, then let the core fetch
    task automatic run(input logic f, input int i, input logic av);
        logic [31:0] v;
        logic [15:0] j;
        v = (32'(1) << i) | ($random(seed) & ~((32'(2) << i) - 32'(1)));
        j = f ? FIFO_JUMP_ADDR : USB_JUMP_ADDR;
        @(posedge clk);
        if (f) fifoEvent <= v[13:0]; else usbEvent <= v[26:0];
        @(posedge clk);
        fifoEvent <= '0;
        usbEvent <= '0;
        @(negedge clk);
        chkLine(1'b1, f ? fifoSharedIrq : usbSharedIrq);
        for (int k = 0; k < 3; k++)
            expB.push_back(8'(k == 2 && av ? (f ? FIFO_VEC_BASE : USB_VEC_BASE) + 8'(4 * i) : 8'(j + k) ^ 8'ha5));
        @(posedge clk);
        go <= 1'b1;
        isFifo <= f;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : run
    // Oldest note against each result
    always @(negedge clk) begin
        if (fetchByteValid === 1'b1) chkByte(expB.pop_front(), fetchByte);
        if (wbAck === 1'b1 && wbReq.we === 1'b0) chk(expRd.pop_front(), wbDatOut);
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, OFS_VECTORS, {16'h0, FIFO_VEC_BASE, USB_VEC_BASE});
        bus(0, 8'h40, 32'h0);
        $display("test reset done");
        bus(1, OFS_SETUP, 32'((1 << SETUP_USB_AV_BIT) | (1 << SETUP_FIFO_AV_BIT)));
        @(posedge clk);
        fifoEvent <= 14'h0020;
        @(posedge clk);
        fifoEvent <= '0;
        @(negedge clk);
        chkLine(1'b0, fifoSharedIrq);
        bus(1, OFS_FIFO_EN, 32'h3fff);
        chkLine(1'b1, fifoSharedIrq);
        bus(0, OFS_FIFO_PEND, 32'h20);
        // Clear the flag, or it would outrank the lower-priority runs below
        bus(1, OFS_FIFO_PEND, 32'h20);
        chkLine(1'b0, fifoSharedIrq);
        bus(1, OFS_USB_EN, 32'h7ff_ffff);
        $display("test masking done");
        for (int i = 13; i >= 0; i--) run(1, i, 1);
        for (int i = 26; i >= 0; i--) run(0, i, 1);
        $display("test priority done");
        bus(1, OFS_SETUP, 32'h0);
        run(1, 3, 0);
        run(0, 9, 0);
        bus(1, OFS_FIFO_PEND, 32'h3fff);
        bus(1, OFS_USB_PEND, 32'h7ff_ffff);
        chkLine(1'b0, usbSharedIrq);
        chkLine(1'b0, fifoSharedIrq);
        $display("test passthrough done");
        // Mid-run reset drops a live line and clears the enables
        @(posedge clk);
        usbEvent <= 27'h0000001;
        @(posedge clk);
        usbEvent <= '0;
        @(negedge clk);
        chkLine(1'b1, usbSharedIrq);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chkLine(1'b0, usbSharedIrq);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, OFS_USB_EN, 32'h0);
        $display("test reset again done");
        wrapUp();
    end
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        nErrors++;
        wrapUp();
    end
endmodule : test_interrupt_autovector
bind iav_autovector iav_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .usbEvent(usbEvent), .fifoEvent(fifoEvent), .usbSharedIrq(usbSharedIrq),
    .fifoSharedIrq(fifoSharedIrq), .fetchReq(fetchReq), .fetchByte(fetchByte), .fetchByteValid(fetchByteValid));
`default_nettype wire
